// ==== src/phy_bmc_regs.vh ====
/*
 * constants for the upper part of the basic mode control register:
 * offset, field positions, reset values and timing counts.
 * assumes it is included by bare name from the design files.
 */
`ifndef PHY_BMC_REGS_VH
`define PHY_BMC_REGS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define BMC_ADDR_W 5
`define BMC_DATA_W 16
`define BMC_OFFSET 5'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BMC_SOFT_RESET_BIT 15
`define BMC_LOOPBACK_BIT 14
`define BMC_SPEED_BIT 13
`define BMC_AUTONEG_BIT 12
`define BMC_RESERVED_BIT 11

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BMC_SOFT_RESET_RST 1'h0
`define BMC_LOOPBACK_RST 1'h0
`define BMC_SPEED_RST 1'h1
`define BMC_AUTONEG_RST 1'h1

// ----------------------------------------------------------------
// strap codes {autoneg_strap_high, autoneg_strap_low}
// ----------------------------------------------------------------
`define STRAP_FORCE_10 2'h1
`define STRAP_FORCE_100 2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define SOFT_RESET_NS 1000
`define SOFT_RESET_CYCLES (`SOFT_RESET_NS / `CLK_PERIOD_NS)
`define LOOP_DEAD_US 550
`define LOOP_DEAD_CYCLES ((`LOOP_DEAD_US * 1000) / `CLK_PERIOD_NS)
`define POWER_ON_WAIT_US 500

`endif

// ==== src/strap_latch.v ====
/*
 * strap latch: captures the two negotiation strap pins once after
 * the hardware reset is released and again on each resample request.
 * assumes strap pins are steady and synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module strap_latch #(
    parameter WIDTH = 2
) (
    input wire core_clk,
    input wire rst_b,
    input wire [WIDTH-1:0] strap_pins,
    input wire resample,
    output reg [WIDTH-1:0] strap_value,
    output reg strap_loaded
);

    reg pending_reg;

    // ----------------------------------------------------------------
    // capture after release and on request
    // ----------------------------------------------------------------
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pending_reg <= 1'h1;
            strap_value <= {WIDTH{1'b0}};
            strap_loaded <= 1'h0;
        end else begin
            pending_reg <= 1'h0;
            strap_loaded <= pending_reg | resample;
            if (pending_reg | resample) begin
                strap_value <= strap_pins;
            end
        end
    end

endmodule

`default_nettype wire

// ==== src/phy_basic_mode_control.v ====
/*
 * upper bits (15..11) of the basic mode control register with the
 * soft reset sequencer, strap reload, loopback path and speed and
 * negotiation selection.
 * assumes the management frame logic presents decoded register
 * accesses as single-cycle strobes synchronous to core_clk.
 */
//
// Contract
// R1 - writing bit 15 returns all status and control registers to defaults
// R2 - soft reset re-samples the strap pins like a hardware reset
// R3 - bit 15 reads one while resetting, zero once finished
// R4 - manager waits 500 us after power on before soft reset
// R5 - loopback bit routes transmit data back to receive data
// R6 - loopback at 100 Mb/s may impose a 550 us dead time
// R7 - loopback bit overrides loopback bits 8 and 9 of register 18h
// R8 - bit 13 picks 100 or 10 Mb/s when negotiation disabled
// R9 - speed bit value ignored while negotiation enabled
// R10 - negotiation straps set speed and override bit 12
// R11 - negotiation disabled: bits 8 and 13 set speed and duplex
// R12 - negotiation off at reset needs clear then set to enable
// R13 - registers are 16-bit words, up to 32 addresses
// R14 - defaults: bits 15,14 zero, 13,12 one; bit 11 reads zero
// R15 - bit 12 reads last written value, never status
`timescale 1ns/1ps
`default_nettype none
`include "phy_bmc_regs.vh"

module phy_basic_mode_control #(
    parameter DEAD_CYCLES = `LOOP_DEAD_CYCLES,
    parameter RESET_CYCLES = `SOFT_RESET_CYCLES,
    parameter NIB_W = 4
) (
    input wire core_clk,
    input wire rst_b,
    input wire [`BMC_ADDR_W-1:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [`BMC_DATA_W-1:0] reg_wdata,
    output reg [`BMC_DATA_W-1:0] reg_rdata,
    input wire autoneg_strap_low,
    input wire autoneg_strap_high,
    input wire [1:0] loopback_bypass_mode,
    input wire an_speed_100,
    input wire [NIB_W-1:0] tx_data,
    input wire tx_en,
    input wire [NIB_W-1:0] line_rx_data,
    input wire line_rx_dv,
    output reg [NIB_W-1:0] rx_data,
    output reg rx_dv,
    output reg [NIB_W-1:0] line_tx_data,
    output reg line_tx_en,
    output reg regs_reset,
    output reg loopback_en,
    output reg [1:0] loop_mode,
    output reg speed_100,
    output reg autoneg_en
);

    localparam ST_IDLE = 2'h0;
    localparam ST_HOLD = 2'h1;
    localparam ST_LATCH = 2'h2;
    localparam CNT_W = 16;
    localparam [CNT_W-1:0] RESET_LOAD = RESET_CYCLES[CNT_W-1:0];
    localparam [CNT_W-1:0] DEAD_LOAD = DEAD_CYCLES[CNT_W-1:0];

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [CNT_W-1:0] rst_cnt_reg;
    reg loop_reg;
    reg speed_reg;
    reg an_ctrl_reg;
    reg an_active_reg;
    reg an_armed_reg;
    reg [CNT_W-1:0] dead_cnt_reg;
    reg resample_reg;
    wire [1:0] strap_value;
    wire strap_loaded;
    wire bmc_hit;
    wire wr_hit;
    wire busy;
    wire strap_forced;
    wire eff_speed;
    wire in_dead;
    wire soft_req;
    wire dead_start;
    wire strap_100;

    // ----------------------------------------------------------------
    // access decode and effective modes
    // ----------------------------------------------------------------
    assign bmc_hit = (reg_addr == `BMC_OFFSET);
    assign busy = (state_reg != ST_IDLE);
    // writes refused while busy so a reset cannot restart midway
    assign wr_hit = reg_wr & bmc_hit & ~busy;
    // R1 soft reset request
    assign soft_req = wr_hit & reg_wdata[`BMC_SOFT_RESET_BIT];
    // R10 straps override
    assign strap_forced = (strap_value == `STRAP_FORCE_10) |
                          (strap_value == `STRAP_FORCE_100);
    assign strap_100 = (strap_value == `STRAP_FORCE_100);
    // R8 R9 R11 speed choice
    assign eff_speed = an_active_reg ? an_speed_100 : speed_reg;
    assign in_dead = (dead_cnt_reg != {CNT_W{1'b0}});
    // R6 loopback entry at 100 Mb/s opens the dead time
    assign dead_start = loop_reg & ~loopback_en & eff_speed;

    // ----------------------------------------------------------------
    // strap capture
    // ----------------------------------------------------------------
    strap_latch #(
        .WIDTH(2)
    ) u_strap (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .strap_pins({autoneg_strap_high, autoneg_strap_low}),
        .resample(resample_reg),
        .strap_value(strap_value),
        .strap_loaded(strap_loaded)
    );

    // ----------------------------------------------------------------
    // soft reset sequencer
    // ----------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (soft_req) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // count runs with the other registers held at defaults
                if (rst_cnt_reg == {CNT_W{1'b0}}) begin
                    state_next = ST_LATCH;
                end
            end
            ST_LATCH: begin
                // wait for the resampled straps to be applied
                if (strap_loaded) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            rst_cnt_reg <= {CNT_W{1'b0}};
            resample_reg <= 1'h0;
            regs_reset <= 1'h0;
        end else begin
            state_reg <= state_next;
            // R2 strap resample at end of hold
            resample_reg <= (state_reg == ST_HOLD) &&
                            (state_next == ST_LATCH);
            // R1 other registers held at defaults
            regs_reset <= (state_next != ST_IDLE);
            // reload while idle so every reset gets a full hold
            if (state_reg == ST_IDLE) begin
                rst_cnt_reg <= RESET_LOAD;
            end else if (rst_cnt_reg != {CNT_W{1'b0}}) begin
                rst_cnt_reg <= rst_cnt_reg - 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // control bits
    // ----------------------------------------------------------------
    // strap load outranks register writes, so straps set the
    // power-up and post-reset defaults
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            loop_reg <= `BMC_LOOPBACK_RST;
            speed_reg <= `BMC_SPEED_RST;
            an_ctrl_reg <= `BMC_AUTONEG_RST;
            an_active_reg <= `BMC_AUTONEG_RST;
            an_armed_reg <= `BMC_AUTONEG_RST;
        end else if (strap_loaded) begin
            // R10 strap defaults take precedence
            loop_reg <= `BMC_LOOPBACK_RST;
            if (strap_forced) begin
                speed_reg <= strap_100;
                an_ctrl_reg <= 1'h0;
                an_active_reg <= 1'h0;
                an_armed_reg <= 1'h0;
            end else begin
                speed_reg <= `BMC_SPEED_RST;
                an_ctrl_reg <= `BMC_AUTONEG_RST;
                an_active_reg <= `BMC_AUTONEG_RST;
                an_armed_reg <= `BMC_AUTONEG_RST;
            end
        end else if (soft_req) begin
            // R1 defaults on soft reset
            loop_reg <= `BMC_LOOPBACK_RST;
            speed_reg <= `BMC_SPEED_RST;
            an_ctrl_reg <= `BMC_AUTONEG_RST;
            an_active_reg <= `BMC_AUTONEG_RST;
            an_armed_reg <= `BMC_AUTONEG_RST;
        end else if (wr_hit) begin
            loop_reg <= reg_wdata[`BMC_LOOPBACK_BIT];
            // R9 stored but unused while negotiating
            speed_reg <= reg_wdata[`BMC_SPEED_BIT];
            // R15 read back is last written
            an_ctrl_reg <= reg_wdata[`BMC_AUTONEG_BIT];
            // armed clears when straps force negotiation off; a zero
            // write re-arms, so a lone set is ignored
            // R12 clear then set enables
            if (!reg_wdata[`BMC_AUTONEG_BIT]) begin
                an_active_reg <= 1'h0;
                an_armed_reg <= 1'h1;
            end else if (an_armed_reg) begin
                an_active_reg <= 1'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // register read
    // ----------------------------------------------------------------
    // read data holds until the next read strobe
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= {`BMC_DATA_W{1'b0}};
        end else if (reg_rd) begin
            reg_rdata <= {`BMC_DATA_W{1'b0}};
            // R13 one 16-bit word, other addresses zero
            if (bmc_hit) begin
                // R3 reads one while busy
                reg_rdata[`BMC_SOFT_RESET_BIT] <= busy;
                reg_rdata[`BMC_LOOPBACK_BIT] <= loop_reg;
                reg_rdata[`BMC_SPEED_BIT] <= speed_reg;
                reg_rdata[`BMC_AUTONEG_BIT] <= an_ctrl_reg;
                // R14 reserved reads zero
                reg_rdata[`BMC_RESERVED_BIT] <= 1'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // mode outputs and dead time
    // ----------------------------------------------------------------
    // registered copies so the mode pins never glitch
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            loopback_en <= 1'h0;
            loop_mode <= 2'h0;
            speed_100 <= `BMC_SPEED_RST;
            autoneg_en <= `BMC_AUTONEG_RST;
            dead_cnt_reg <= {CNT_W{1'b0}};
        end else begin
            loopback_en <= loop_reg;
            // R7 loopback bit overrides 18h bits
            loop_mode <= loop_reg ? 2'h0 : loopback_bypass_mode;
            speed_100 <= eff_speed;
            autoneg_en <= an_active_reg;
            // R6 dead time on loopback entry at 100
            // leaving loopback cancels any remaining dead time
            if (dead_start) begin
                dead_cnt_reg <= DEAD_LOAD;
            end else if (!loop_reg) begin
                dead_cnt_reg <= {CNT_W{1'b0}};
            end else if (in_dead) begin
                dead_cnt_reg <= dead_cnt_reg - 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // data path
    // ----------------------------------------------------------------
    // one cycle of latency in both directions
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_data <= {NIB_W{1'b0}};
            rx_dv <= 1'h0;
            line_tx_data <= {NIB_W{1'b0}};
            line_tx_en <= 1'h0;
        end else if (loop_reg) begin
            // R5 transmit looped to receive
            rx_data <= tx_data;
            // entry cycle blanked before the counter has loaded
            rx_dv <= tx_en & ~in_dead & ~dead_start;
            // line side idle while looped
            line_tx_data <= {NIB_W{1'b0}};
            line_tx_en <= 1'h0;
        end else begin
            rx_data <= line_rx_data;
            rx_dv <= line_rx_dv;
            line_tx_data <= tx_data;
            line_tx_en <= tx_en;
        end
    end

endmodule

`default_nettype wire

// ==== testbench/bmc_props.sv ====
/* checker for the basic mode control block.
   assumes a bind onto phy_basic_mode_control. */
`timescale 1ns/1ps
`default_nettype none
module bmc_props #(
    parameter NIB_W = 4
) (
    input wire core_clk,
    input wire rst_b,
    input wire [4:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire [NIB_W-1:0] tx_data,
    input wire [NIB_W-1:0] rx_data,
    input wire rx_dv,
    input wire line_tx_en,
    input wire regs_reset,
    input wire loopback_en,
    input wire [1:0] loop_mode,
    input wire speed_100
);
    // ------
    // checks
    // ------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_unmapped_reads_zero: assert property (
        reg_rd && reg_addr != 5'h00 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_low_bits_zero: assert property (
        reg_rd |=> reg_rdata[11:0] == 12'h000)
        else $error("reserved bits not zero");
    a_soft_reset_start: assert property (
        reg_wr && reg_addr == 5'h00 && reg_wdata[15] && !regs_reset
        |=> regs_reset) else $error("soft reset not started");
    a_soft_reset_ends: assert property (
        $rose(regs_reset) |-> ##[1:40] !regs_reset)
        else $error("soft reset never ends");
    a_busy_reads_one: assert property (
        reg_rd && reg_addr == 5'h00 && regs_reset |=> reg_rdata[15])
        else $error("busy reset bit read zero");
    a_loop_line_quiet: assert property (
        loopback_en |-> !line_tx_en) else $error("line driven in loopback");
    a_loop_data: assert property (
        loopback_en && $past(loopback_en) |-> rx_data == $past(tx_data))
        else $error("loopback data wrong");
    a_loop_overrides: assert property (
        loopback_en |-> loop_mode == 2'h0) else $error("loop mode not 0");
    a_dead_time: assert property (
        $rose(loopback_en) && speed_100 |-> !rx_dv [*8])
        else $error("no dead time");
endmodule
`default_nettype wire

// ==== testbench/mgmt_station_model.sv ====
/* management station model: register writes and reads.
   assumes strobes are taken on the rising core_clk edge. */
`timescale 1ns/1ps
`default_nettype none
module mgmt_station_model (
    input wire core_clk,
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    input wire [15:0] reg_rdata
);
    initial begin
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ==== testbench/phy_basic_mode_control_test.sv ====
/* self-checking bench for the basic mode control block.
   assumes a 20 MHz core_clk and the management station model. */
`timescale 1ns/1ps
`default_nettype none
module phy_basic_mode_control_test;
    localparam NIB_W = 4;
    logic core_clk = 1'b0, rst_b = 1'b0, reg_wr, reg_rd;
    logic strap_lo = 1'b0, strap_hi = 1'b0, an_speed_100 = 1'b0;
    logic tx_en = 1'b0, rx_dv, line_tx_en, regs_reset, loopback_en;
    logic speed_100, autoneg_en;
    logic [1:0] lb_mode = 2'h0, loop_mode;
    logic [3:0] tx_data = 4'h0, rx_data, line_tx_data;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    int errors = 0, cmp_count = 0, cycles = 0, n;
    always #25 core_clk = ~core_clk;
    always @(negedge core_clk) tx_data <= tx_data + 4'h1;
    mgmt_station_model u_mgmt_station_model (.core_clk(core_clk),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    phy_basic_mode_control #(.DEAD_CYCLES(20), .RESET_CYCLES(20))
    u_phy_basic_mode_control (.core_clk(core_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .autoneg_strap_low(strap_lo), .autoneg_strap_high(strap_hi),
        .loopback_bypass_mode(lb_mode), .an_speed_100(an_speed_100),
        .tx_data(tx_data), .tx_en(tx_en), .line_rx_data(4'h0),
        .line_rx_dv(1'b0), .rx_data(rx_data), .rx_dv(rx_dv),
        .line_tx_data(line_tx_data), .line_tx_en(line_tx_en),
        .regs_reset(regs_reset), .loopback_en(loopback_en),
        .loop_mode(loop_mode), .speed_100(speed_100),
        .autoneg_en(autoneg_en));
    // ----------
    // helpers
    // ----------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (3) @(negedge core_clk);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_defaults();
        u_mgmt_station_model.rd(5'h00, d);
        chk(d, 16'h3000);
        u_mgmt_station_model.wr(5'h05, 16'hFFFF);
        u_mgmt_station_model.rd(5'h05, d);
        chk(d, 16'h0000);
        u_mgmt_station_model.rd(5'h00, d);
        chk(d, 16'h3000);
    endtask
    task automatic t_speed();
        u_mgmt_station_model.wr(5'h00, 16'h2FFF);
        u_mgmt_station_model.rd(5'h00, d);
        chk(d, 16'h2000);
        chk(16'(speed_100), 16'h1);
        chk(16'(autoneg_en), 16'h0);
        u_mgmt_station_model.wr(5'h00, 16'h0000);
        settle();
        chk(16'(speed_100), 16'h0);
        an_speed_100 = 1'b1;
        u_mgmt_station_model.wr(5'h00, 16'h1000);
        settle();
        chk(16'(autoneg_en), 16'h1);
        chk(16'(speed_100), 16'h1);
        u_mgmt_station_model.rd(5'h00, d);
        chk(d, 16'h1000);
    endtask
    task automatic t_loop();
        lb_mode = 2'h3;
        tx_en = 1'b1;
        u_mgmt_station_model.wr(5'h00, 16'h5000);
        settle();
        chk(16'(loop_mode), 16'h0);
        chk(16'(loopback_en), 16'h1);
        chk(16'(line_tx_en), 16'h0);
        chk(16'(rx_dv), 16'h0);
        repeat (25) @(negedge core_clk);
        chk(16'(rx_dv), 16'h1);
        chk(16'(rx_data), 16'(tx_data));
        u_mgmt_station_model.wr(5'h00, 16'h1000);
        settle();
        chk(16'(loop_mode), 16'h3);
        chk(16'(line_tx_en), 16'h1);
        chk(16'(line_tx_data), 16'(tx_data));
        chk(16'(rx_dv), 16'h0);
    endtask
    task automatic t_soft();
        strap_lo = 1'b1;
        // power-on wait, 500 us is 10000 cycles
        while (cycles < 10000) @(negedge core_clk);
        u_mgmt_station_model.wr(5'h00, 16'h4000);
        u_mgmt_station_model.wr(5'h00, 16'h8000);
        u_mgmt_station_model.rd(5'h00, d);
        chk(16'(d[15]), 16'h1);
        chk(d, 16'hB000);
        n = 0;
        while (regs_reset === 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        settle();
        u_mgmt_station_model.rd(5'h00, d);
        chk(d, 16'h0000);
        chk(16'(speed_100), 16'h0);
        u_mgmt_station_model.wr(5'h00, 16'h1000);
        settle();
        chk(16'(autoneg_en), 16'h0);
        u_mgmt_station_model.wr(5'h00, 16'h0000);
        u_mgmt_station_model.wr(5'h00, 16'h1000);
        settle();
        chk(16'(autoneg_en), 16'h1);
    endtask
    task automatic t_strap100();
        an_speed_100 = 1'b0;
        strap_lo = 1'b0;
        strap_hi = 1'b1;
        u_mgmt_station_model.wr(5'h00, 16'h8000);
        n = 0;
        while (regs_reset === 1'b1 && n < 100) begin
            @(negedge core_clk);
            n++;
        end
        settle();
        u_mgmt_station_model.rd(5'h00, d);
        chk(d, 16'h2000);
        chk(16'(speed_100), 16'h1);
        chk(16'(autoneg_en), 16'h0);
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 11000) begin
            errors++;
            $display("mismatch at %0t: timeout", $time);
            wrap_up();
        end
    end
    initial begin
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
        t_defaults();
        t_speed();
        t_loop();
        t_soft();
        t_strap100();
        wrap_up();
    end
endmodule
bind phy_basic_mode_control bmc_props #(.NIB_W(NIB_W)) u_bmc_props (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .tx_data(tx_data), .rx_data(rx_data),
    .rx_dv(rx_dv), .line_tx_en(line_tx_en), .regs_reset(regs_reset),
    .loopback_en(loopback_en), .loop_mode(loop_mode),
    .speed_100(speed_100));
`default_nettype wire
